// ### dbt_channel.sv
/*
  byte transfer channel core: apb register file, transaction sequencer,
  one-byte buffer and the source and destination pointer/counter pairs.
  assumes an apb master, and a system bus with arbiter grant and done.
*/
//
// Overview of operation
// - data moves one byte per transaction; messages are many transactions
// - each transaction reads source into buffer, then writes it out
// - pending flag set while read byte waits, clear once written
// - reads flash, eeprom or ram space; writes only ram space
// - software sets 22-bit source and 16-bit destination start addresses
// - running source and destination pointers update after every transaction
// - each pointer independently holds, increments or decrements by one
// - two-bit selector picks the source memory space
// - on enable sizes are copied into the counters
// - both counters drop by one together after each transaction
// - run request starts a message; smaller counter running out ends it
// - run out clears run request and reloads that counter and pointer
// - uneven sizes end last message early, remainder skews later ones
// - a counter leaving one reloads at once, never reads zero
// - mode codes: 00 hold, 01 increment, 10 decrement
// - enable loads pointers and counters from starts and sizes
// - the bus is used only after the arbiter grants it
`timescale 1ns/1ps
`default_nettype none
module dbt_channel
  import dbt_pkg::*;
#(
  parameter int SAW = DBT_SADDR_W,
  parameter int DAW = DBT_DADDR_W,
  parameter int CW  = DBT_CNT_W
) (
  input  wire logic           pclk,       // system clock
  input  wire logic           presetn,    // async reset, low
  input  wire logic           psel,       // apb select
  input  wire logic           penable,    // apb access phase
  input  wire logic           pwrite,     // apb direction
  input  wire logic [7:0]     paddr,      // apb byte address
  input  wire logic [31:0]    pwdata,     // apb write data
  input  wire logic [3:0]     pstrb,      // apb byte strobes
  output logic      [31:0]    prdata,     // apb read data
  output logic                pready,     // apb ready
  output logic                pslverr,    // apb error
  output logic                rd_req,     // source read request
  output logic      [SAW-1:0] rd_addr,    // source read address
  output logic      [1:0]     rd_space,   // source memory space
  input  wire logic           rd_grant,   // arbiter grant for read
  input  wire logic           rd_done,    // read data valid
  input  wire logic [7:0]     rd_data,    // byte read
  output logic                wr_req,     // destination write request
  output logic      [DAW-1:0] wr_addr,    // destination write address
  output logic      [7:0]     wr_data,    // byte to write
  input  wire logic           wr_grant,   // arbiter grant for write
  input  wire logic           wr_done,    // write taken
  output logic                running     // message in progress
);

  // pointer widths are fixed by the two bus address ranges; a counter must
  // fit the low half of the read word and needs at least two bits
  initial begin
    if (SAW != DBT_SADDR_W || DAW != DBT_DADDR_W || CW < 2 || CW > 16)
      $error("dbt_channel: unsupported widths");
  end

  // sequencer states; the fourth code is unused
  typedef enum logic [1:0] {
    DBT_IDLE,
    DBT_READ,
    DBT_WRITE
  } dbt_state_type;

  dbt_state_type state_q;

  // control, status and configuration state
  logic           en_q;
  logic           run_q;
  logic           xip_q;
  logic [1:0]     source_address_mode_q;
  logic [1:0]     destination_address_mode_q;
  logic [1:0]     ssel_q;
  logic [7:0]     buf_q;
  logic [SAW-1:0] ssa_q;
  logic [DAW-1:0] dsa_q;
  logic [CW-1:0]  ssz_q;
  logic [CW-1:0]  dsz_q;

  // running pointers and counters from the two stepping pairs
  logic [SAW-1:0] sptr;
  logic [DAW-1:0] dptr;
  logic [CW-1:0]  scnt;
  logic [CW-1:0]  dcnt;

  // sequencing strobes
  logic           swrap;
  logic           dwrap;
  logic           en_rise;
  logic           rd_fin;
  logic           wr_fin;
  logic           rd_go;
  logic           wr_go;
  logic           stop;
  logic           step;

  // apb write strobe, taken in the access phase
  // no wait states, so a write lands at the access-phase edge
  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;

  // unmapped offsets answer with an error
  // the byte address is decoded whole; unmapped words read as zero
  logic addr_ok;
  always_comb begin
    unique case (paddr)
      DBT_CTRL_A_OFS, DBT_CTRL_B_OFS, DBT_BUF_OFS, DBT_SSA_OFS, DBT_SPTR_OFS,
      DBT_SSZ_OFS, DBT_SCNT_OFS, DBT_DSA_OFS, DBT_DPTR_OFS, DBT_DSZ_OFS,
      DBT_DCNT_OFS: addr_ok = 1'b1;
      default:      addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  // enable bit and its rising edge
  // only the rising edge loads pointers and counters; a repeated
  // enable write leaves a running message where it is
  logic en_wr;
  assign en_wr  = wr_en && paddr == DBT_CTRL_A_OFS && pstrb[0];
  assign en_rise = en_wr && pwdata[DBT_A_EN_BIT] && !en_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_q <= 1'b0;
    else if (en_wr) en_q <= pwdata[DBT_A_EN_BIT];
  end

  // run request: set by software while enabled, cleared on run out
  // a run out in the same cycle as a software set wins, so a message
  // never restarts on the edge that ended it; setting an already set
  // bit changes nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_q <= 1'b0;
    else if (!en_q) run_q <= 1'b0;
    else if (swrap || dwrap) run_q <= 1'b0;
    else if (en_wr) run_q <= pwdata[DBT_A_RUN_BIT] && pwdata[DBT_A_EN_BIT];
  end

  // configuration fields of channel_control_b, frozen while running
  // a mode change mid-message would skew the pointers, so a write while running is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_address_mode_q <= DBT_MODE_HOLD;
      destination_address_mode_q <= DBT_MODE_HOLD;
      ssel_q  <= DBT_SPACE_RAM;
    end else if (wr_en && paddr == DBT_CTRL_B_OFS && pstrb[0] && !run_q) begin
      destination_address_mode_q <= pwdata[DBT_B_DESTINATION_ADDRESS_MODE_LSB +: 2];
      ssel_q  <= pwdata[DBT_B_SSEL_LSB +: 2];
      source_address_mode_q <= pwdata[DBT_B_SOURCE_ADDRESS_MODE_LSB +: 2];
    end
  end

  // start addresses and sizes
  // frozen while a message runs so reload values cannot shift under it;
  // a size of zero is refused because a counter must never read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ssa_q <= '0;
      dsa_q <= '0;
      ssz_q <= CW'(DBT_SIZE_RST);
      dsz_q <= CW'(DBT_SIZE_RST);
    end else if (wr_en && !run_q) begin
      unique case (paddr)
        DBT_SSA_OFS: ssa_q <= pwdata[SAW-1:0];
        DBT_DSA_OFS: dsa_q <= pwdata[DAW-1:0];
        DBT_SSZ_OFS: if (pwdata[CW-1:0] != '0) ssz_q <= pwdata[CW-1:0];
        DBT_DSZ_OFS: if (pwdata[CW-1:0] != '0) dsz_q <= pwdata[CW-1:0];
        default: ;
      endcase
    end
  end

  // stop: run request falls (soft stop) or enable is cleared (hard stop)
  // either stop also drops any bus request that is still waiting
  assign stop = !run_q || !en_q;

  // transaction sequencer: read phase, then write phase
  // a soft stop leaves the pending byte in the buffer; when run is set
  // again the sequencer goes straight to the write, so that byte is
  // neither lost nor read twice. a hard stop clears the pending flag,
  // so the next message always begins with a fresh source read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_q <= DBT_IDLE;
    else begin
      unique case (state_q)
        DBT_IDLE:  if (!stop) state_q <= xip_q ? DBT_WRITE : DBT_READ;
        DBT_READ:  if (stop) state_q <= DBT_IDLE;
                   else if (rd_fin) state_q <= DBT_WRITE;
        DBT_WRITE: if (stop) state_q <= DBT_IDLE;
                   else if (wr_fin) state_q <= DBT_IDLE;
        default:   state_q <= DBT_IDLE;  // unused fourth code
      endcase
    end
  end

  // one start per phase; a stop blocks a fresh start
  assign rd_go = state_q == DBT_READ && !rd_req && !stop;
  assign wr_go = state_q == DBT_WRITE && !wr_req && !stop;
  // a transaction counts once its write lands; an aborted write never steps
  assign step  = wr_fin;

  // one-byte buffer holds the read until the write completes
  // after a soft stop it still holds the byte not yet written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) buf_q <= 8'h00;
    else if (rd_fin) buf_q <= rd_data;
  end

  // pending flag; a hard stop drops the pending byte
  // set by the read completion, cleared by the write completion; the
  // two never meet because the sequencer is in one phase at a time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) xip_q <= 1'b0;
    else if (!en_q) xip_q <= 1'b0;
    else if (rd_fin) xip_q <= 1'b1;
    else if (wr_fin) xip_q <= 1'b0;
  end

  // source side bus access, any of three spaces
  // the space code travels with the address; the bus decodes it
  dbt_bus_port u_rd (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (rd_go),
    .abort   (stop),
    .grant   (rd_grant),
    .done    (rd_done),
    .req     (rd_req),
    .fin     (rd_fin)
  );

  // destination side bus access, ram space only
  // no space code: the destination is always ram space
  dbt_bus_port u_wr (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (wr_go),
    .abort   (stop),
    .grant   (wr_grant),
    .done    (wr_done),
    .req     (wr_req),
    .fin     (wr_fin)
  );

  // source pointer and counter
  // both pairs step on the same write completion; each reloads on its
  // own when it leaves one, and both reload together on even sizes
  dbt_ptr_step #(.AW(SAW), .CW(CW)) u_src (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (en_rise),
    .step    (step),
    .mode    (source_address_mode_q),
    .start   (ssa_q),
    .size    (ssz_q),
    .ptr_q   (sptr),
    .cnt_q   (scnt),
    .wrap    (swrap)
  );

  // destination pointer and counter
  // wraps at its own narrower width
  dbt_ptr_step #(.AW(DAW), .CW(CW)) u_dst (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (en_rise),
    .step    (step),
    .mode    (destination_address_mode_q),
    .start   (dsa_q),
    .size    (dsz_q),
    .ptr_q   (dptr),
    .cnt_q   (dcnt),
    .wrap    (dwrap)
  );

  // bus addresses follow the running pointers
  // they change only on a step or an enable load, never while a request waits
  assign rd_addr  = sptr;
  assign rd_space = ssel_q;
  assign wr_addr  = dptr;
  assign wr_data  = buf_q;
  assign running  = run_q;

  // apb read mux, registered data
  // fields sit in the low bits; unused bits read as zero
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      DBT_CTRL_A_OFS: begin
        rdata_d[DBT_A_EN_BIT]  = en_q;
        rdata_d[DBT_A_RUN_BIT] = run_q;
        rdata_d[DBT_A_XIP_BIT] = xip_q;
      end
      DBT_CTRL_B_OFS: begin
        rdata_d[DBT_B_DESTINATION_ADDRESS_MODE_LSB +: 2] = destination_address_mode_q;
        rdata_d[DBT_B_SSEL_LSB +: 2]  = ssel_q;
        rdata_d[DBT_B_SOURCE_ADDRESS_MODE_LSB +: 2] = source_address_mode_q;
      end
      DBT_BUF_OFS:  rdata_d[7:0]     = buf_q;
      DBT_SSA_OFS:  rdata_d[SAW-1:0] = ssa_q;
      DBT_SPTR_OFS: rdata_d[SAW-1:0] = sptr;
      DBT_SSZ_OFS:  rdata_d[CW-1:0]  = ssz_q;
      DBT_SCNT_OFS: rdata_d[CW-1:0]  = scnt;
      DBT_DSA_OFS:  rdata_d[DAW-1:0] = dsa_q;
      DBT_DPTR_OFS: rdata_d[DAW-1:0] = dptr;
      DBT_DSZ_OFS:  rdata_d[CW-1:0]  = dsz_q;
      DBT_DCNT_OFS: rdata_d[CW-1:0]  = dcnt;
      default: ;
    endcase
  end

  // read data captured in the setup cycle, valid in the access phase
  // pready is tied high, so every transfer takes two cycles; capturing
  // one edge early keeps prdata a flop output for the whole access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= rdata_d;
  end

  // read strobe and upper byte lanes carry no meaning here; only lane 0
  // gates the control registers, wide registers take the whole word
  logic unused_rd;
  logic unused_strb;
  assign unused_rd   = rd_en;
  assign unused_strb = |pstrb[3:1];

endmodule : dbt_channel
`default_nettype wire

// ### dbt_pkg.sv
/*
  package for the byte transfer channel: register offsets, field positions,
  reset values, address modes and source spaces.
  assumes an apb slave with 32-bit data, one aligned word per register.
*/
package dbt_pkg;

  // register byte offsets
  localparam logic [7:0] DBT_CTRL_A_OFS = 8'h00;  // channel_control_a
  localparam logic [7:0] DBT_CTRL_B_OFS = 8'h04;  // channel_control_b
  localparam logic [7:0] DBT_BUF_OFS    = 8'h08;  // byte_buffer
  localparam logic [7:0] DBT_SSA_OFS    = 8'h0C;  // source start address
  localparam logic [7:0] DBT_SPTR_OFS   = 8'h10;  // source pointer
  localparam logic [7:0] DBT_SSZ_OFS    = 8'h14;  // source size
  localparam logic [7:0] DBT_SCNT_OFS   = 8'h18;  // source counter
  localparam logic [7:0] DBT_DSA_OFS    = 8'h1C;  // destination start address
  localparam logic [7:0] DBT_DPTR_OFS   = 8'h20;  // destination pointer
  localparam logic [7:0] DBT_DSZ_OFS    = 8'h24;  // destination size
  localparam logic [7:0] DBT_DCNT_OFS   = 8'h28;  // destination counter

  // channel_control_a bits
  localparam int DBT_A_EN_BIT  = 7;  // channel enable
  localparam int DBT_A_RUN_BIT = 5;  // run_request_bit
  localparam int DBT_A_XIP_BIT = 4;  // transfer_pending_flag, read only

  // channel_control_b fields
  localparam int DBT_B_DESTINATION_ADDRESS_MODE_LSB = 6;  // destination_address_mode
  localparam int DBT_B_SSEL_LSB  = 3;  // source_space_select
  localparam int DBT_B_SOURCE_ADDRESS_MODE_LSB = 1;  // source_address_mode

  // address modes
  typedef enum logic [1:0] {
    DBT_MODE_HOLD = 2'b00,
    DBT_MODE_INC  = 2'b01,
    DBT_MODE_DEC  = 2'b10
  } dbt_mode_type;

  // source spaces
  localparam logic [1:0] DBT_SPACE_RAM    = 2'h0;  // register / ram space
  localparam logic [1:0] DBT_SPACE_EEPROM = 2'h1;  // data eeprom
  localparam logic [1:0] DBT_SPACE_FLASH  = 2'h2;  // program flash

  // widths and reset values
  localparam int DBT_SADDR_W = 22;
  localparam int DBT_DADDR_W = 16;
  localparam int DBT_CNT_W   = 12;
  localparam logic [11:0] DBT_SIZE_RST = 12'h001;

endpackage : dbt_pkg

// ### dbt_ptr_step.sv
/*
  one pointer and counter pair: advances after each transaction and
  reloads from size and start address when the counter is at one.
  assumes load and step never come in the same cycle from the owner.
*/
`timescale 1ns/1ps
`default_nettype none
module dbt_ptr_step
  import dbt_pkg::*;
#(
  parameter int AW = 16,
  parameter int CW = 12
) (
  input  wire logic          pclk,     // system clock
  input  wire logic          presetn,  // async reset, low
  input  wire logic          load,     // initial load on enable
  input  wire logic          step,     // one transaction done
  input  wire logic [1:0]    mode,     // address mode
  input  wire logic [AW-1:0] start,    // start address
  input  wire logic [CW-1:0] size,     // message size
  output logic      [AW-1:0] ptr_q,    // current pointer
  output logic      [CW-1:0] cnt_q,    // current counter
  output logic               wrap      // counter runs out this step
);

  initial begin
    if (AW < 1 || CW < 2) $error("dbt_ptr_step: bad widths");
  end

  // counter is about to run out
  assign wrap = step && (cnt_q == CW'(1));

  // pointer and counter update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= '0;
      cnt_q <= CW'(DBT_SIZE_RST);
    end else if (load || wrap) begin
      ptr_q <= start;
      cnt_q <= size;
    end else if (step) begin
      cnt_q <= cnt_q - CW'(1);
      unique case (mode)
        DBT_MODE_INC: ptr_q <= ptr_q + AW'(1);
        DBT_MODE_DEC: ptr_q <= ptr_q - AW'(1);
        default:      ptr_q <= ptr_q;
      endcase
    end
  end

endmodule : dbt_ptr_step
`default_nettype wire

// ### dbt_bus_port.sv
/*
  system bus port: raises a request, waits for the arbiter grant, then
  completes one byte access when the bus answers done.
  assumes the bus keeps grant until done and done follows grant.
*/
`timescale 1ns/1ps
`default_nettype none
module dbt_bus_port
  import dbt_pkg::*;
(
  input  wire logic pclk,     // system clock
  input  wire logic presetn,  // async reset, low
  input  wire logic start,    // begin an access
  input  wire logic abort,    // drop the access
  input  wire logic grant,    // arbiter grant
  input  wire logic done,     // bus access done
  output logic      req,      // bus request
  output logic      fin       // access finished, one cycle
);

  logic busy_q;

  // request held until the granted access completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_q <= 1'b0;
    else if (abort) busy_q <= 1'b0;
    else if (busy_q && grant && done) busy_q <= 1'b0;
    else if (start) busy_q <= 1'b1;
  end

  assign req = busy_q;
  assign fin = busy_q && grant && done && !abort;

endmodule : dbt_bus_port
`default_nettype wire

// ### dbt_bus_model.sv
/*
  system bus partner: arbiter grant plus memory that answers byte accesses.
  assumes one request at a time per side and a steady slow input.
*/
`timescale 1ns/1ps
`default_nettype none
module dbt_bus_model
  import dbt_pkg::*;
(
  input  wire logic        pclk,      // system clock
  input  wire logic        presetn,   // async reset, low
  input  wire logic        slow,      // stall each grant
  input  wire logic        rd_req,    // read request
  input  wire logic [21:0] rd_addr,   // read address
  input  wire logic [1:0]  rd_space,  // read space
  input  wire logic        wr_req,    // write request
  output logic             rd_grant,  // read grant
  output logic             rd_done,   // read answered
  output logic [7:0]       rd_data,   // read byte
  output logic             wr_grant,  // write grant
  output logic             wr_done    // write taken
);
  logic [2:0] dly;
  logic [2:0] rw_q;
  logic [2:0] ww_q;
  logic [7:0] pat_q;
  // stall length; the model never touches arbiter or channel registers
  assign dly = slow ? 3'd5 : 3'd0;
  // grant only a waiting request, one cycle, after the stall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_grant <= 1'b0;
      wr_grant <= 1'b0;
      rw_q     <= 3'd0;
      ww_q     <= 3'd0;
      pat_q    <= 8'h00;
    end else begin
      rd_grant <= rd_req && !rd_grant && rw_q == dly;
      wr_grant <= wr_req && !wr_grant && ww_q == dly;
      rw_q     <= (rd_req && !rd_grant) ? rw_q + 3'(rw_q != dly) : 3'd0;
      ww_q     <= (wr_req && !wr_grant) ? ww_q + 3'(ww_q != dly) : 3'd0;
      pat_q    <= pat_q + 8'h5B;
    end
  end
  // answer with grant; bus data churns when not granted
  assign rd_done = rd_grant;
  assign wr_done = wr_grant;
  assign rd_data = rd_grant ? (rd_addr[7:0] ^ {rd_space, rd_addr[13:8]}) : pat_q;
endmodule : dbt_bus_model
`default_nettype wire

// ### dbt_channel_monitor.sv
/*
  checker for the byte transfer channel ports.
  assumes it is bound into dbt_channel and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module dbt_channel_monitor
  import dbt_pkg::*;
#(
  parameter int SAW = DBT_SADDR_W,
  parameter int DAW = DBT_DADDR_W
) (
  input wire logic           pclk,      // system clock
  input wire logic           presetn,   // async reset, low
  input wire logic           psel,      // apb select
  input wire logic           penable,   // apb access
  input wire logic           pwrite,    // apb direction
  input wire logic [7:0]     paddr,     // apb address
  input wire logic [31:0]    prdata,    // apb read data
  input wire logic           rd_req,    // read request
  input wire logic [SAW-1:0] rd_addr,   // read address
  input wire logic [1:0]     rd_space,  // read space
  input wire logic           rd_grant,  // read grant
  input wire logic           rd_done,   // read done
  input wire logic           wr_req,    // write request
  input wire logic [DAW-1:0] wr_addr,   // write address
  input wire logic [7:0]     wr_data,   // write byte
  input wire logic           wr_grant,  // write grant
  input wire logic           wr_done,   // write done
  input wire logic           running    // run bit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus ordering and holding
  a_one_request: assert property (!(rd_req && wr_req))
    else $error("read and write requested together");
  a_read_holds: assert property (rd_req && !(rd_grant && rd_done) |=>
    !rd_req || ($stable(rd_addr) && $stable(rd_space))) else $error("read request moved");
  a_write_holds: assert property (wr_req && !(wr_grant && wr_done) |=>
    !wr_req || ($stable(wr_addr) && $stable(wr_data))) else $error("write request moved");
  a_read_then_write: assert property (rd_req && rd_grant && rd_done && running
    |-> ##[1:3] (wr_req || !running)) else $error("no write after read");
  a_write_follows: assert property ($rose(wr_req) |-> $past(rd_req && rd_done, 1)
    || $past(rd_req && rd_done, 2) || $past(rd_req && rd_done, 3) || !$past(running, 3))
    else $error("write without read");
  a_gap_after_write: assert property ($fell(wr_req) |-> !rd_req)
    else $error("read directly after write");
  a_stopped_quiet: assert property (!running [*2] |-> !rd_req && !wr_req)
    else $error("request while stopped");
  a_count_nonzero: assert property (psel && penable && !pwrite &&
    (paddr == DBT_SCNT_OFS || paddr == DBT_DCNT_OFS) |-> prdata[11:0] != 12'h000)
    else $error("counter read zero");
endmodule : dbt_channel_monitor
bind dbt_channel dbt_channel_monitor #(.SAW(SAW), .DAW(DAW)) u_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .rd_req(rd_req), .rd_addr(rd_addr), .rd_space(rd_space),
  .rd_grant(rd_grant), .rd_done(rd_done), .wr_req(wr_req), .wr_addr(wr_addr),
  .wr_data(wr_data), .wr_grant(wr_grant), .wr_done(wr_done), .running(running));
`default_nettype wire

// ### dma_byte_transfer_core_tb_top.sv
/*
  testbench: apb master, bus partner and a reference of pointers and counters.
  assumes dbt_channel, dbt_bus_model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module dma_byte_transfer_core_tb_top
  import dbt_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [7:0] paddr = 0, rd_data, wr_data, lb;
  logic [31:0] pwdata = 0, prdata, seed = 32'h0000ED70;
  logic pready, pslverr, rd_req, rd_grant, rd_done, wr_req, wr_grant, wr_done, running;
  logic [21:0] rd_addr, ssa, sptr;
  logic [15:0] wr_addr, dsa, dptr;
  logic [11:0] ss, ds, es, ed;
  logic [1:0] rd_space, sm, dm, sp;
  logic [11:0] ssz [4] = '{12'h001, 12'h003, 12'h002, 12'h005};
  logic [11:0] dsz [4] = '{12'h003, 12'h002, 12'h006, 12'h003};
  int mismatches = 0, checks_done = 0, xact, x;
  // clock
  always #50 pclk = ~pclk;
  dbt_channel DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_space(rd_space), .rd_grant(rd_grant), .rd_done(rd_done), .rd_data(rd_data),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_grant(wr_grant),
    .wr_done(wr_done), .running(running));
  dbt_bus_model u_bus (.pclk(pclk), .presetn(presetn), .slow(slow), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_space(rd_space), .wr_req(wr_req), .rd_grant(rd_grant),
    .rd_done(rd_done), .rd_data(rd_data), .wr_grant(wr_grant), .wr_done(wr_done));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin mismatches++; conclude(); end
  endtask : apb
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : w
  task automatic rd(input logic [7:0] a, input logic [31:0] xp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK("prdata", xp, q)
    `CHK("pslverr", a > DBT_DCNT_OFS, e)
  endtask : rd
  // bounded wait: sel 1 for a write request, 0 for the message end
  task automatic wait_until(input int sel);
    int n;
    n = 0;
    do begin @(posedge pclk); n++; end
    while ((sel ? wr_req !== 1'b1 : running !== 1'b0) && n < 3000);
    if (sel ? wr_req !== 1'b1 : running !== 1'b0) begin
      mismatches++;
      $display("[ERR] wait_until exp %0d got %0d", sel, sel ? wr_req : running);
      conclude();
    end
  endtask : wait_until
  // reference: check each bus result, then step pointers and counters
  always @(posedge pclk) begin
    if (rd_req && rd_grant && rd_done) begin
      `CHK("rd_addr", sptr, rd_addr)
      `CHK("rd_space", sp, rd_space)
    end
    if (wr_req && wr_grant && wr_done) begin
      `CHK("wr_addr", dptr, wr_addr)
      `CHK("wr_data", sptr[7:0] ^ {sp, sptr[13:8]}, wr_data)
      lb = sptr[7:0] ^ {sp, sptr[13:8]};
      xact++;
      sptr = (es == 1) ? ssa : (sm == 1) ? sptr + 1'b1 : (sm == 2) ? sptr - 1'b1 : sptr;
      dptr = (ed == 1) ? dsa : (dm == 1) ? dptr + 1'b1 : (dm == 2) ? dptr - 1'b1 : dptr;
      es = (es == 1) ? ss : es - 1'b1;
      ed = (ed == 1) ? ds : ed - 1'b1;
    end
  end
  // main sequence: reset, reset values, then four channel setups
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(DBT_SCNT_OFS, 32'h1);
    rd(DBT_SSZ_OFS, 32'(DBT_SIZE_RST));
    rd(8'h40, 32'h0);
    for (int i = 0; i < 4; i++) begin
      sm = 2'(i % 3);
      dm = 2'((i + 2) % 3);
      sp = 2'(i % 3);
      ssa = (i == 2) ? 22'h0 : 22'(xs());
      dsa = (i == 2) ? 16'hFFFF : 16'(xs());
      ss = ssz[i];
      ds = dsz[i];
      slow <= (i == 3);
      w(DBT_CTRL_A_OFS, 32'h0);
      w(DBT_CTRL_B_OFS, {24'h0, dm, 1'b0, sp, sm, 1'b0});
      w(DBT_SSA_OFS, 32'(ssa));
      w(DBT_DSA_OFS, 32'(dsa));
      w(DBT_SSZ_OFS, 32'(ss));
      w(DBT_DSZ_OFS, 32'(ds));
      w(DBT_CTRL_A_OFS, 32'h80);
      sptr = ssa;
      dptr = dsa;
      es = ss;
      ed = ds;
      rd(DBT_SPTR_OFS, 32'(ssa));
      rd(DBT_DCNT_OFS, 32'(ds));
      for (int m = 0; m < 3; m++) begin
        x = (es < ed) ? es : ed;
        xact = 0;
        w(DBT_CTRL_A_OFS, 32'hA0);
        if (slow && m == 0) begin
          wait_until(1);
          rd(DBT_CTRL_A_OFS, 32'hB0);
          `CHK("running", 1'b1, running)
        end
        wait_until(0);
        `CHK("transactions", x, xact)
        rd(DBT_SCNT_OFS, 32'(es));
        rd(DBT_DCNT_OFS, 32'(ed));
        rd(DBT_SPTR_OFS, 32'(sptr));
        rd(DBT_DPTR_OFS, 32'(dptr));
        rd(DBT_CTRL_A_OFS, 32'h80);
        rd(DBT_BUF_OFS, 32'(lb));
      end
    end
    conclude();
  end
endmodule : dma_byte_transfer_core_tb_top
`default_nettype wire
